// ---- shared/piu_pkg.sv ----
// Shared constants and carriers for the priority interrupt unit
package piu_pkg;

  // Source counts
  localparam int NUM_ACTIVE  = 191;
  localparam int NUM_RSVD    = 165;
  localparam int NUM_PERIPH  = NUM_ACTIVE + NUM_RSVD;
  localparam int NUM_SW      = 8;
  localparam int NUM_SRC     = NUM_SW + NUM_PERIPH;

  // Vector map: software sources first, then peripherals
  localparam int SW_BASE     = 0;
  localparam int PERIPH_BASE = NUM_SW;

  // Field widths
  localparam int VEC_W       = 9;
  localparam int PRIO_W      = 4;
  localparam int NUM_PRIO    = 16;

  // Saved-priority stack
  localparam int LIFO_DEPTH  = 16;
  localparam int LIFO_AW     = 4;
  localparam int SP_W        = 5;

  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int LAT_MAX_CLK   = 3;

  typedef logic [PRIO_W-1:0] piu_prio_t;
  typedef logic [VEC_W-1:0]  piu_vec_t;
  typedef logic [SP_W-1:0]   piu_sp_t;

  localparam piu_prio_t PRIO_RST = 4'h0;
  localparam piu_vec_t  VEC_RST  = 9'h000;
  localparam piu_sp_t   SP_EMPTY = 5'h00;
  localparam piu_sp_t   SP_ONE   = 5'h01;
  localparam piu_sp_t   SP_FULL  = 5'h10;

  // Processor and software control strobes, one cycle each
  typedef struct packed {
    logic      hw_ack;
    logic      vec_read;
    logic      eoi;
    logic      ceil_wr;
    piu_prio_t ceil_prio;
  } piu_ctl_s;

  // Status seen by processor and software
  typedef struct packed {
    logic      irq;
    piu_vec_t  vector;
    piu_prio_t cur_prio;
    piu_sp_t   depth;
    logic      overflow;
  } piu_stat_s;

endpackage : piu_pkg

// ---- rtl/piu_arbiter.sv ----
// Highest-priority pending source search, registered result
`timescale 1ns/100ps
module piu_arbiter (
  // Clock and reset
  input  wire logic                               mclk,
  input  wire logic                               reset,
  // Pending requests and their levels
  input  wire logic [piu_pkg::NUM_SRC-1:0]        req,
  input  wire piu_pkg::piu_prio_t [piu_pkg::NUM_SRC-1:0] prio,
  // Winner
  output logic                                    valid_q,
  output piu_pkg::piu_prio_t                      prio_q,
  output piu_pkg::piu_vec_t                       idx_q
);
  import piu_pkg::*;

  logic      best_v;
  piu_prio_t best_p;
  piu_vec_t  best_i;

  // Strict compare keeps the lowest index on a tie
  always_comb begin
    best_v = 1'b0;
    best_p = PRIO_RST;
    best_i = VEC_RST;
    for (int i = 0; i < NUM_SRC; i++) begin
      if (req[i] && (!best_v || prio[i] > best_p)) begin
        best_v = 1'b1;
        best_p = prio[i];
        best_i = piu_vec_t'(i);
      end
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      valid_q <= 1'b0;
      prio_q  <= PRIO_RST;
      idx_q   <= VEC_RST;
    end else begin
      valid_q <= best_v;
      prio_q  <= best_p;
      idx_q   <= best_i;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  arb_follows_a: assert property ((|req) |=> valid_q)
    else $error("pending request not seen by arbiter");
  arb_tie_a: assert property (
    (req[0] && (prio[0] == best_p)) |=> (idx_q == VEC_RST))
    else $error("tie not resolved toward lower index");

endmodule : piu_arbiter

// ---- rtl/piu_lifo.sv ----
// Stack of preempted priorities with registered top
`timescale 1ns/100ps
module piu_lifo (
  // Clock and reset
  input  wire logic               mclk,
  input  wire logic               reset,
  // Stack operations
  input  wire logic               push,
  input  wire logic               pop,
  input  wire piu_pkg::piu_prio_t din,
  // State
  output piu_pkg::piu_prio_t      top_q,
  output piu_pkg::piu_sp_t        depth_q,
  output logic                    full,
  output logic                    empty
);
  import piu_pkg::*;

  piu_prio_t mem [LIFO_DEPTH];
  piu_sp_t   below;
  logic      do_push;
  logic      do_pop;

  assign full    = (depth_q == SP_FULL);
  assign empty   = (depth_q == SP_EMPTY);
  assign below   = depth_q - SP_ONE;
  assign do_push = push && !full;
  assign do_pop  = pop && !empty && !push;

  // Top lives in a register; storage only holds entries beneath it
  always_ff @(posedge mclk) begin
    if (do_push) begin
      mem[depth_q[LIFO_AW-1:0]] <= top_q;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      top_q <= PRIO_RST;
    end else if (do_push) begin
      top_q <= din;
    end else if (do_pop) begin
      top_q <= mem[below[LIFO_AW-1:0]];
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      depth_q <= SP_EMPTY;
    end else if (do_push) begin
      depth_q <= depth_q + SP_ONE;
    end else if (do_pop) begin
      depth_q <= below;
    end
  end

endmodule : piu_lifo

// ---- rtl/piu_priority_irq_unit.sv ----
// Preemptive priority interrupt unit top
//
// Summary of operation
// - 356 peripheral request lines, 165 of them reserved
// - Eight software-set requests, arbitrated like peripherals
// - Each source has its own 9-bit vector
// - Vector on output pins and readable by software
// - Per-source 16-level priority steers arbitration
// - Only strictly higher priority preempts current
// - Push current priority on accept, pop later
// - Software may rewrite current priority for ceiling
// - Processor request within three clocks of input
// - NMI bypasses arbitration and masking entirely
`timescale 1ns/100ps
module piu_priority_irq_unit (
  // Clock and reset
  input  wire logic                              mclk,
  input  wire logic                              reset,
  // Peripheral requests, same clock domain
  input  wire logic [piu_pkg::NUM_PERIPH-1:0]    periph_req,
  // Software request set and clear strobes
  input  wire logic [piu_pkg::NUM_SW-1:0]        sw_set,
  input  wire logic [piu_pkg::NUM_SW-1:0]        sw_clr,
  // Per-source priority, indexed by vector
  input  wire piu_pkg::piu_prio_t [piu_pkg::NUM_SRC-1:0] src_prio,
  // Acknowledge, end of interrupt and ceiling write
  input  wire piu_pkg::piu_ctl_s                 ctl,
  // Non-maskable request pin
  input  wire logic                              nmi_pin,
  // Processor side status
  output piu_pkg::piu_stat_s                     stat,
  // Software-readable acknowledged vector
  output piu_pkg::piu_vec_t                      ack_vec_q,
  // Software request pending bits
  output logic [piu_pkg::NUM_SW-1:0]             sw_pend_q,
  // Non-maskable request to the core
  output logic                                   nmi_out_q
);
  import piu_pkg::*;

  logic [NUM_SRC-1:0] req_all;
  logic               win_valid_q;
  piu_prio_t          win_prio_q;
  piu_vec_t           win_idx_q;

  logic               irq_q;
  piu_vec_t           vec_q;
  piu_prio_t          irq_prio_q;
  piu_prio_t          cur_prio_q;
  logic               overflow_q;
  logic               nmi_meta_q;

  piu_prio_t          lifo_top;
  piu_sp_t            lifo_depth;
  logic               lifo_full;
  logic               lifo_empty;

  logic               ack_any;
  logic               take;
  logic               eoi_ok;
  logic               win_hi;

  // Software sources sit below the peripherals in vector space
  assign req_all = {periph_req, sw_pend_q};

  piu_arbiter u_arb (
    .mclk    (mclk),
    .reset   (reset),
    .req     (req_all),
    .prio    (src_prio),
    .valid_q (win_valid_q),
    .prio_q  (win_prio_q),
    .idx_q   (win_idx_q)
  );

  // Hardware acknowledge and software vector read act alike
  assign ack_any = ctl.hw_ack | ctl.vec_read;
  assign eoi_ok  = ctl.eoi && !lifo_empty;
  // A full stack refuses nesting rather than lose a level
  assign take    = irq_q && ack_any && !ctl.eoi && !lifo_full;
  assign win_hi  = win_valid_q && (win_prio_q > cur_prio_q);

  piu_lifo u_lifo (
    .mclk    (mclk),
    .reset   (reset),
    .push    (take),
    .pop     (eoi_ok),
    .din     (cur_prio_q),
    .top_q   (lifo_top),
    .depth_q (lifo_depth),
    .full    (lifo_full),
    .empty   (lifo_empty)
  );

  // Set wins over clear so a late set is not lost
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      sw_pend_q <= '0;
    end else begin
      sw_pend_q <= (sw_pend_q & ~sw_clr) | sw_set;
    end
  end

  // Request drops in the cycle that changes the current level,
  // so a stale compare never yields a second acknowledge
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= win_hi && !take && !eoi_ok && !ctl.ceil_wr;
    end
  end

  // Vector and level travel with the request
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      vec_q      <= VEC_RST;
      irq_prio_q <= PRIO_RST;
    end else begin
      vec_q      <= win_idx_q;
      irq_prio_q <= win_prio_q;
    end
  end

  // End of interrupt beats acknowledge beats ceiling write
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      cur_prio_q <= PRIO_RST;
    end else if (eoi_ok) begin
      cur_prio_q <= lifo_top;
    end else if (take) begin
      cur_prio_q <= irq_prio_q;
    end else if (ctl.ceil_wr) begin
      cur_prio_q <= ctl.ceil_prio;
    end
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      ack_vec_q <= VEC_RST;
    end else if (take) begin
      ack_vec_q <= vec_q;
    end
  end

  // Sticky until reset; tells software nesting was refused
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      overflow_q <= 1'b0;
    end else if (irq_q && ack_any && !ctl.eoi && lifo_full) begin
      overflow_q <= 1'b1;
    end
  end

  // Pin is asynchronous: two stages, no other logic on the path
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      nmi_meta_q <= 1'b0;
      nmi_out_q  <= 1'b0;
    end else begin
      nmi_meta_q <= nmi_pin;
      nmi_out_q  <= nmi_meta_q;
    end
  end

  assign stat = '{irq:      irq_q,
                  vector:   vec_q,
                  cur_prio: cur_prio_q,
                  depth:    lifo_depth,
                  overflow: overflow_q};

  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  sequence took_s;
    take;
  endsequence

  sequence popped_s;
    eoi_ok;
  endsequence

  sequence quiet_s;
    !take && !eoi_ok && !ctl.ceil_wr;
  endsequence

  sequence refused_s;
    irq_q && ack_any && !ctl.eoi && lifo_full;
  endsequence

  sequence ceiled_s;
    ctl.ceil_wr && !take && !eoi_ok;
  endsequence

  sequence idle_sw_s;
    !(|sw_set) && !(|sw_clr);
  endsequence

  irq_strict_a: assert property (
    irq_q |-> $past(win_valid_q) && ($past(win_prio_q) > $past(cur_prio_q)))
    else $error("request raised without a higher pending level");

  irq_fast_a: assert property ((win_hi and quiet_s) |=> irq_q)
    else $error("request to processor late");

  irq_end_a: assert property ((periph_req[0] && src_prio[PERIPH_BASE] > cur_prio_q
    && !ack_any && !ctl.eoi && !ctl.ceil_wr)[*3] |-> irq_q)
    else $error("peripheral request not raised within three clocks");

  ack_push_a: assert property (took_s |=>
    (cur_prio_q == $past(irq_prio_q)) && (lifo_top == $past(cur_prio_q))
    && (lifo_depth == $past(lifo_depth) + SP_ONE))
    else $error("accept did not save and raise the level");

  nest_restore_a: assert property ((took_s ##1 popped_s) |=>
    cur_prio_q == $past(cur_prio_q, 2))
    else $error("saved level not restored at end of interrupt");

  ceiling_a: assert property ((ctl.ceil_wr && !eoi_ok && !take) |=>
    cur_prio_q == $past(ctl.ceil_prio))
    else $error("ceiling write not applied");

  ceiling_hold_a: assert property (quiet_s |=> $stable(cur_prio_q))
    else $error("current level moved without cause");

  sw_set_a: assert property ((|sw_set) |=>
    ((sw_pend_q & $past(sw_set)) == $past(sw_set)))
    else $error("software request set lost");

  vec_latch_a: assert property (took_s |=>
    (ack_vec_q == $past(vec_q)) && !irq_q)
    else $error("acknowledged vector not latched");

  nmi_pass_a: assert property (##2 (nmi_out_q == $past(nmi_pin, 2)))
    else $error("non-maskable path not a plain two-stage delay");

  // A refused accept is reported, never half done
  overflow_set_a: assert property (refused_s |=>
    overflow_q && $stable(lifo_depth))
    else $error("refused nesting not flagged");

  // Sticky so software may look late
  overflow_keep_a: assert property (
    overflow_q |=> overflow_q)
    else $error("overflow flag cleared without reset");

  overflow_only_a: assert property (
    (!overflow_q && !(irq_q && ack_any && !ctl.eoi && lifo_full)) |=> !overflow_q)
    else $error("overflow flag set without a refused accept");

  full_keep_a: assert property (
    (lifo_full && !ctl.eoi) |=> lifo_full)
    else $error("full stack changed without a pop");

  // Depth moves only by a push or a pop
  lifo_step_a: assert property ((!take && !eoi_ok) |=> $stable(lifo_depth))
    else $error("stack depth moved without push or pop");

  pop_level_a: assert property (popped_s |=>
    (lifo_depth == $past(lifo_depth) - SP_ONE) && !irq_q)
    else $error("end of interrupt did not pop one level");

  cur_eoi_a: assert property (popped_s |=> (cur_prio_q == $past(lifo_top)))
    else $error("popped level not restored");

  eoi_bound_a: assert property (ctl.eoi |=> (lifo_depth <= $past(lifo_depth)))
    else $error("stack grew on end of interrupt");

  // End of interrupt wins over an acknowledge in the same cycle
  eoi_beats_a: assert property ((ctl.eoi && ack_any && !lifo_empty) |=>
    (lifo_depth == $past(lifo_depth) - SP_ONE))
    else $error("acknowledge beat end of interrupt");

  // Stray end of interrupt on an empty stack is ignored
  eoi_empty_a: assert property ((ctl.eoi && lifo_empty && !ctl.ceil_wr) |=>
    $stable(cur_prio_q) && lifo_empty)
    else $error("end of interrupt on empty stack acted");

  ceil_no_push_a: assert property (ceiled_s |=> $stable(lifo_depth))
    else $error("ceiling write touched the stack");

  irq_drop_a: assert property (
    (took_s or popped_s or ctl.ceil_wr) |=> !irq_q)
    else $error("request held across a level change");

  irq_refuse_a: assert property (
    (!win_valid_q || (win_prio_q <= cur_prio_q)) |=> !irq_q)
    else $error("request raised for an equal or lower level");

  take_higher_a: assert property (
    took_s |-> (irq_prio_q > cur_prio_q))
    else $error("accepted request not above current level");

  sw_clr_a: assert property ((|sw_clr) |=>
    ((sw_pend_q & $past(sw_clr) & ~$past(sw_set)) == '0))
    else $error("software request clear lost");

  sw_keep_a: assert property (
    idle_sw_s |=> $stable(sw_pend_q))
    else $error("software request moved without a strobe");

  ackvec_keep_a: assert property ((!take) |=> $stable(ack_vec_q))
    else $error("acknowledged vector moved without an accept");

endmodule : piu_priority_irq_unit

// ---- sim/piu_core_model.sv ----
// Processor core model taking interrupts over the hardware vector
`timescale 1ns/100ps
module piu_core_model (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              reset,
  // Behaviour
  input  wire logic              en,
  input  wire logic [3:0]        dly,
  // Unit side
  input  wire piu_pkg::piu_stat_s stat,
  output logic                   hw_ack_q,
  output piu_pkg::piu_vec_t      got_vec_q
);
  import piu_pkg::*;
  logic [3:0] wait_q;
  // Acks only while irq stands, so a dropped request is never taken
  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      hw_ack_q  <= 1'b0;
      got_vec_q <= 9'h000;
      wait_q    <= 4'h0;
    end else begin
      hw_ack_q <= 1'b0;
      if (hw_ack_q && stat.irq) got_vec_q <= stat.vector;
      if (!en || !stat.irq) wait_q <= 4'h0;
      else if (!hw_ack_q) begin
        if (wait_q >= dly) begin
          hw_ack_q <= 1'b1;
          wait_q   <= 4'h0;
        end else wait_q <= wait_q + 4'h1;
      end
    end
  end
endmodule : piu_core_model

// ---- sim/piu_priority_irq_unit_tb_top.sv ----
// Self-checking bench for the priority interrupt unit
`timescale 1ns/100ps
module piu_priority_irq_unit_tb_top;
  import piu_pkg::*;
  logic                  mclk, reset, nmi_pin, core_en, vr, eo, cw, core_ack, nmi_out_q;
  logic [NUM_PERIPH-1:0] periph_req;
  logic [NUM_SW-1:0]     sw_set, sw_clr, sw_pend_q;
  piu_prio_t [NUM_SRC-1:0] src_prio;
  piu_prio_t             cp;
  piu_ctl_s              ctl;
  piu_stat_s             stat;
  piu_vec_t              ack_vec_q, got_vec;
  int                    err_total, n_compared;
  assign ctl = {core_ack, vr, eo, cw, cp};

  piu_priority_irq_unit uut (.mclk(mclk), .reset(reset), .periph_req(periph_req),
    .sw_set(sw_set), .sw_clr(sw_clr), .src_prio(src_prio), .ctl(ctl), .nmi_pin(nmi_pin),
    .stat(stat), .ack_vec_q(ack_vec_q), .sw_pend_q(sw_pend_q), .nmi_out_q(nmi_out_q));
  piu_core_model core (.mclk(mclk), .reset(reset), .en(core_en), .dly(4'h3), .stat(stat),
    .hw_ack_q(core_ack), .got_vec_q(got_vec));

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic req(input int k, input logic v);
    @(posedge mclk);
    periph_req[k] <= v;
  endtask : req

  // One-cycle control strobe, result sampled after the taking edge
  task automatic strobe(input logic e, input logic v, input logic c, input piu_prio_t p);
    @(posedge mclk);
    eo <= e;
    vr <= v;
    cw <= c;
    cp <= p;
    @(posedge mclk);
    eo <= 1'b0;
    vr <= 1'b0;
    cw <= 1'b0;
    #1;
  endtask : strobe

  // Bounded wait for the stack to reach a depth
  task automatic wait_depth(input piu_sp_t d);
    for (int i = 0; i < 20 && stat.depth !== d; i++) tick(1);
  endtask : wait_depth

  task automatic t_periph;
    req(0, 1'b1);
    tick(3);
    chk("irq", 1, stat.irq);
    chk("vector", 8, stat.vector);
    @(posedge mclk) core_en <= 1'b1;
    wait_depth(SP_ONE);
    chk("cur_prio", 5, stat.cur_prio);
    chk("ack_vec", 8, ack_vec_q);
    chk("core_vec", 8, got_vec);
  endtask : t_periph

  task automatic t_preempt;
    req(355, 1'b1);
    wait_depth(5'h02);
    chk("core_vec", 363, got_vec);
    chk("cur_prio", 9, stat.cur_prio);
    @(posedge mclk) core_en <= 1'b0;
    req(190, 1'b1);
    tick(4);
    chk("irq_equal", 0, stat.irq);
    strobe(1'b1, 1'b0, 1'b0, 4'h0);
    chk("cur_pop", 5, stat.cur_prio);
    chk("depth_pop", 1, stat.depth);
    tick(3);
    chk("irq_tie", 1, stat.irq);
    chk("vec_tie", 198, stat.vector);
    strobe(1'b0, 1'b1, 1'b0, 4'h0);
    chk("ack_vec_rd", 198, ack_vec_q);
    chk("depth_rd", 2, stat.depth);
    @(posedge mclk) periph_req <= '0;
    strobe(1'b1, 1'b0, 1'b0, 4'h0);
    strobe(1'b1, 1'b0, 1'b0, 4'h0);
    chk("depth_end", 0, stat.depth);
    chk("cur_end", 0, stat.cur_prio);
  endtask : t_preempt

  task automatic t_ceiling;
    strobe(1'b0, 1'b0, 1'b1, 4'hf);
    chk("cur_ceil", 15, stat.cur_prio);
    chk("depth_ceil", 0, stat.depth);
    req(100, 1'b1);
    tick(4);
    chk("irq_ceil", 0, stat.irq);
    strobe(1'b0, 1'b0, 1'b1, 4'h0);
    tick(3);
    chk("irq_lower", 1, stat.irq);
    chk("vec_ceil", 108, stat.vector);
    req(100, 1'b0);
    tick(3);
  endtask : t_ceiling

  // Set beats clear in the same cycle; software beats peripheral on a tie
  task automatic t_soft;
    req(1, 1'b1);
    @(posedge mclk);
    sw_set <= 8'h09;
    sw_clr <= 8'h08;
    @(posedge mclk);
    sw_set <= 8'h00;
    sw_clr <= 8'h00;
    tick(4);
    chk("sw_pend", 8'h09, sw_pend_q);
    chk("irq_sw", 1, stat.irq);
    chk("vec_sw0", 0, stat.vector);
    @(posedge mclk) sw_clr <= 8'h01;
    @(posedge mclk) sw_clr <= 8'h00;
    tick(4);
    chk("vec_sw", 3, stat.vector);
    @(posedge mclk) sw_clr <= 8'h08;
    @(posedge mclk) sw_clr <= 8'h00;
    tick(4);
    chk("sw_pend_clr", 0, sw_pend_q);
    chk("vec_periph", 9, stat.vector);
    req(1, 1'b0);
    tick(3);
  endtask : t_soft

  // Accept then pop at once, then fill the stack by lowering the level each time
  task automatic t_nest;
    req(100, 1'b1);
    tick(3);
    @(posedge mclk);
    vr <= 1'b1;
    @(posedge mclk);
    vr <= 1'b0;
    eo <= 1'b1;
    @(posedge mclk);
    eo <= 1'b0;
    #1;
    chk("ack_vec_nest", 108, ack_vec_q);
    chk("cur_nest", 0, stat.cur_prio);
    chk("depth_nest", 0, stat.depth);
    repeat (17) begin
      strobe(1'b0, 1'b0, 1'b1, 4'h0);
      strobe(1'b0, 1'b1, 1'b0, 4'h0);
    end
    chk("depth_full", 16, stat.depth);
    chk("overflow", 1, stat.overflow);
    chk("cur_full", 0, stat.cur_prio);
    req(100, 1'b0);
    strobe(1'b1, 1'b1, 1'b0, 4'h0);
    chk("depth_both", 15, stat.depth);
    repeat (16) strobe(1'b1, 1'b0, 1'b0, 4'h0);
    chk("depth_empty", 0, stat.depth);
    chk("cur_empty", 0, stat.cur_prio);
  endtask : t_nest

  task automatic t_nmi;
    @(posedge mclk) nmi_pin <= 1'b1;
    tick(1);
    chk("nmi_early", 0, nmi_out_q);
    tick(1);
    chk("nmi_out", 1, nmi_out_q);
    chk("irq_nmi", 0, stat.irq);
    @(posedge mclk) nmi_pin <= 1'b0;
  endtask : t_nmi

  task automatic complete_run;
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    #20000;
    err_total++;
    complete_run();
  end

  initial begin
    {reset, core_en, nmi_pin, vr, eo, cw} = 6'h20;
    {periph_req, sw_set, sw_clr, cp, src_prio} = '0;
    {err_total, n_compared} = '0;
    src_prio[0]   = 4'h2;
    src_prio[3]   = 4'h2;
    src_prio[8]   = 4'h5;
    src_prio[9]   = 4'h2;
    src_prio[108] = 4'he;
    src_prio[198] = 4'h9;
    src_prio[363] = 4'h9;
    core_en = 1'b0;
    tick(1);
    chk("stat_rst", 0, stat);
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    t_periph();
    t_preempt();
    t_ceiling();
    t_soft();
    t_nest();
    t_nmi();
    complete_run();
  end
endmodule : piu_priority_irq_unit_tb_top
